/* design/scss_map.vh */
// register offsets, field positions, codes and timing constants for the serial channel status bank
// Overview of operation
// - config word bit0 linked, bit1 eight data bits, bit2 parity on, bit3 even parity
// - config word bit4 two stop bits, bit5 sum check, bit6 online change, bit7 modify
// - bits 8-11 hold baud code per table, 50 bps is f; bits 12-15 read zero
// - 230400 bps code accepted on channel one only
// - protocol code 0 to 9, e and f; other values not accepted
// - host station number 0 to 31 identifies the module on the command protocol
// - sampled control line states per channel readable at 254h and 264h
// - rts and dtr outputs driven by device logic, not by controller writes
// - stored line status lags the real line by at most 100 ms
`ifndef SCSS_MAP_VH
`define SCSS_MAP_VH

`define SCSS_ADDR_CH1_LINE 12'h254
`define SCSS_ADDR_CH2_LINE 12'h264
`define SCSS_ADDR_CH1_CFG 12'h2a0
`define SCSS_ADDR_CH1_PROT 12'h2a1
`define SCSS_ADDR_CH2_CFG 12'h2a2
`define SCSS_ADDR_CH2_PROT 12'h2a3
`define SCSS_ADDR_STATION 12'h2a4

`define SCSS_CFG_LINKED 0
`define SCSS_CFG_DATA8 1
`define SCSS_CFG_PARITY 2
`define SCSS_CFG_EVEN 3
`define SCSS_CFG_STOP2 4
`define SCSS_CFG_SUM 5
`define SCSS_CFG_ONLINE 6
`define SCSS_CFG_MODIFY 7
`define SCSS_CFG_BAUD_LSB 8
`define SCSS_CFG_BAUD_MSB 11

`define SCSS_BAUD_MAX_LOW 4'hb
`define SCSS_BAUD_230400 4'hc
`define SCSS_BAUD_50 4'hf
`define SCSS_PROT_MAX_STD 4'h9
`define SCSS_PROT_ROMTEST 4'he
`define SCSS_PROT_LOOPBACK 4'hf
`define SCSS_STATION_MAX 5'h1f

`define SCSS_LINE_RTS 0
`define SCSS_LINE_DSR 1
`define SCSS_LINE_DTR 2
`define SCSS_LINE_DCD 3
`define SCSS_LINE_CTS 4
`define SCSS_LINE_RI 5

`define SCSS_CFG_RESET 16'h0000
`define SCSS_PROT_RESET 4'h0
`define SCSS_STATION_RESET 5'h00
`define SCSS_LINE_RESET 6'h00

`define SCSS_LAG_MAX_MS 100
`define SCSS_CLK_MHZ 200
`define SCSS_REFRESH_MS 10
`define SCSS_REFRESH_CYC (`SCSS_REFRESH_MS * `SCSS_CLK_MHZ * 1000)
`define SCSS_LAG_MAX_CYC (`SCSS_LAG_MAX_MS * `SCSS_CLK_MHZ * 1000)
`define SCSS_SYNC_CYC 5

`endif

/* design/scss_line_sync.v */
// three-stage synchroniser with agreement filter for one channel's control lines
`timescale 1ns/1ps
`default_nettype none
module scss_line_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] level_out
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;

  // a change counts once the second and third stages agree
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
      level_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
    end
  end
endmodule // scss_line_sync
`default_nettype wire

/* design/scss_status_bank.v */
// read-only status bank: line settings, protocol codes, station number, control line status
`timescale 1ns/1ps
`default_nettype none
`include "scss_map.vh"
module scss_status_bank #(
  parameter REFRESH_CYC = `SCSS_REFRESH_CYC
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  // settings presented by the module's switch/setting logic
  input wire set_load,
  input wire [15:0] ch1_cfg_in,
  input wire [15:0] ch2_cfg_in,
  input wire [3:0] ch1_prot_in,
  input wire [3:0] ch2_prot_in,
  input wire [4:0] station_in,
  // handshake lines driven by device firmware
  input wire ch1_rts_req,
  input wire ch1_dtr_req,
  input wire ch2_rts_req,
  input wire ch2_dtr_req,
  // rs-232 input pins
  input wire ch1_dsr_pin,
  input wire ch1_dcd_pin,
  input wire ch1_cts_pin,
  input wire ch1_ri_pin,
  input wire ch2_dsr_pin,
  input wire ch2_dcd_pin,
  input wire ch2_cts_pin,
  input wire ch2_ri_pin,
  // buffer memory read port
  input wire rd_en,
  input wire [11:0] rd_addr,
  output reg [15:0] rd_data,
  output reg rd_valid,
  output reg rd_hit,
  // rs-232 output pins, then the settings refusal flag
  output reg ch1_request_to_send_out,
  output reg ch1_dte_ready_out,
  output reg ch2_request_to_send_out,
  output reg ch2_dte_ready_out,
  output reg set_reject
);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // rate code legal for the channel: the table codes, 50 bps, and the fastest code on ch1 only
  function cfg_ok;
    input [15:0] cfg;
    input ch1;
    reg [3:0] b;
    begin
      b = cfg[`SCSS_CFG_BAUD_MSB:`SCSS_CFG_BAUD_LSB];
      cfg_ok = (b <= `SCSS_BAUD_MAX_LOW) || (b == `SCSS_BAUD_50) ||
               ((b == `SCSS_BAUD_230400) && ch1);
    end
  endfunction

  // protocol codes a to d are undefined and refuse the load
  function prot_ok;
    input [3:0] p;
    begin
      prot_ok = (p <= `SCSS_PROT_MAX_STD) || (p == `SCSS_PROT_ROMTEST) ||
                (p == `SCSS_PROT_LOOPBACK);
    end
  endfunction

  // flag and rate fields pass unchanged, the system nibble always reads zero
  function [15:0] clean_cfg;
    input [15:0] cfg;
    begin
      clean_cfg = {4'h0, cfg[`SCSS_CFG_BAUD_MSB:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // setting registers

  reg [15:0] ch1_line_settings_r;
  reg [15:0] ch2_line_settings_r;
  reg [3:0] ch1_protocol_select_r;
  reg [3:0] ch2_protocol_select_r;
  reg [4:0] host_station_number_r;
  reg [15:0] ch1_line_settings_nxt;
  reg [15:0] ch2_line_settings_nxt;
  reg [3:0] ch1_protocol_select_nxt;
  reg [3:0] ch2_protocol_select_nxt;
  reg [4:0] host_station_number_nxt;
  reg set_reject_nxt;
  wire ch1_cfg_good;
  wire ch2_cfg_good;
  wire ch1_prot_good;
  wire ch2_prot_good;
  wire set_good;

  // the fastest rate code is legal on the first channel only
  assign ch1_cfg_good = cfg_ok(ch1_cfg_in, 1'b1);
  assign ch2_cfg_good = cfg_ok(ch2_cfg_in, 1'b0);
  assign ch1_prot_good = prot_ok(ch1_prot_in);
  assign ch2_prot_good = prot_ok(ch2_prot_in);
  // one bad field refuses the whole load
  assign set_good = ch1_cfg_good & ch2_cfg_good & ch1_prot_good & ch2_prot_good;

  ////////////////////////////////////////////////////////////////////////////
  // setting registers: next state

  always @* begin
    ch1_line_settings_nxt = ch1_line_settings_r;
    ch2_line_settings_nxt = ch2_line_settings_r;
    ch1_protocol_select_nxt = ch1_protocol_select_r;
    ch2_protocol_select_nxt = ch2_protocol_select_r;
    host_station_number_nxt = host_station_number_r;
    set_reject_nxt = set_reject;
    if (set_load) begin
      set_reject_nxt = ~set_good;
      if (set_good) begin
        ch1_line_settings_nxt = clean_cfg(ch1_cfg_in);
        ch2_line_settings_nxt = clean_cfg(ch2_cfg_in);
        ch1_protocol_select_nxt = ch1_prot_in;
        ch2_protocol_select_nxt = ch2_prot_in;
        host_station_number_nxt = station_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setting registers: storage

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch1_line_settings_r <= `SCSS_CFG_RESET;
      ch2_line_settings_r <= `SCSS_CFG_RESET;
      ch1_protocol_select_r <= `SCSS_PROT_RESET;
      ch2_protocol_select_r <= `SCSS_PROT_RESET;
      host_station_number_r <= `SCSS_STATION_RESET;
      set_reject <= 1'b0;
    end else if (ce) begin
      ch1_line_settings_r <= ch1_line_settings_nxt;
      ch2_line_settings_r <= ch2_line_settings_nxt;
      ch1_protocol_select_r <= ch1_protocol_select_nxt;
      ch2_protocol_select_r <= ch2_protocol_select_nxt;
      host_station_number_r <= host_station_number_nxt;
      set_reject <= set_reject_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control line outputs, firmware-owned
  // no read or load path reaches these lines

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch1_request_to_send_out <= 1'b0;
      ch1_dte_ready_out <= 1'b0;
      ch2_request_to_send_out <= 1'b0;
      ch2_dte_ready_out <= 1'b0;
    end else if (ce) begin
      ch1_request_to_send_out <= ch1_rts_req;
      ch1_dte_ready_out <= ch1_dtr_req;
      ch2_request_to_send_out <= ch2_rts_req;
      ch2_dte_ready_out <= ch2_dtr_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input line synchronisers
  // pins packed as ri, cts, dcd, dsr to match the status word packing

  wire [3:0] ch1_in_sync;
  wire [3:0] ch2_in_sync;

  scss_line_sync #(.WIDTH(4)) u_sync1 (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin_in({ch1_ri_pin, ch1_cts_pin, ch1_dcd_pin, ch1_dsr_pin}),
    .level_out(ch1_in_sync)
  );

  scss_line_sync #(.WIDTH(4)) u_sync2 (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .pin_in({ch2_ri_pin, ch2_cts_pin, ch2_dcd_pin, ch2_dsr_pin}),
    .level_out(ch2_in_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // periodic refresh of the status words

  // the period in use is capped so that any parameter value still meets the lag bound
  localparam PERIOD_MAX = `SCSS_LAG_MAX_CYC - `SCSS_SYNC_CYC;
  localparam PERIOD_CYC = (REFRESH_CYC < 1) ? 1 :
                          (REFRESH_CYC > PERIOD_MAX) ? PERIOD_MAX : REFRESH_CYC;
  // counter end value, kept at the counter's width
  localparam [31:0] LAST_CNT = PERIOD_CYC - 1;

  reg [31:0] refresh_cnt_r;
  reg [31:0] refresh_cnt_nxt;
  reg [5:0] ch1_line_status_r;
  reg [5:0] ch2_line_status_r;
  reg [5:0] ch1_line_status_nxt;
  reg [5:0] ch2_line_status_nxt;
  wire refresh_tick;

  assign refresh_tick = (refresh_cnt_r == LAST_CNT);

  // bit order of the status word; bits 6-15 stay zero
  function [5:0] pack_lines;
    input rts;
    input dtr;
    input [3:0] ins;
    begin
      pack_lines = 6'h00;
      pack_lines[`SCSS_LINE_RTS] = rts;
      pack_lines[`SCSS_LINE_DSR] = ins[0];
      pack_lines[`SCSS_LINE_DTR] = dtr;
      pack_lines[`SCSS_LINE_DCD] = ins[1];
      pack_lines[`SCSS_LINE_CTS] = ins[2];
      pack_lines[`SCSS_LINE_RI] = ins[3];
    end
  endfunction

  // the status words take a fresh sample once per period, within the lag bound
  always @* begin
    refresh_cnt_nxt = refresh_cnt_r + 32'h0000_0001;
    ch1_line_status_nxt = ch1_line_status_r;
    ch2_line_status_nxt = ch2_line_status_r;
    if (refresh_tick) begin
      refresh_cnt_nxt = 32'h0000_0000;
      ch1_line_status_nxt = pack_lines(ch1_request_to_send_out, ch1_dte_ready_out, ch1_in_sync);
      ch2_line_status_nxt = pack_lines(ch2_request_to_send_out, ch2_dte_ready_out, ch2_in_sync);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // periodic refresh: timer and status word storage

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refresh_cnt_r <= 32'h0000_0000;
      ch1_line_status_r <= `SCSS_LINE_RESET;
      ch2_line_status_r <= `SCSS_LINE_RESET;
    end else if (ce) begin
      refresh_cnt_r <= refresh_cnt_nxt;
      ch1_line_status_r <= ch1_line_status_nxt;
      ch2_line_status_r <= ch2_line_status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer memory read port

  reg [15:0] rd_mux;
  reg rd_map;
  reg [15:0] rd_data_nxt;
  reg rd_valid_nxt;
  reg rd_hit_nxt;

  // unmapped addresses answer zero with the hit flag low
  always @* begin
    rd_mux = 16'h0000;
    rd_map = 1'b1;
    case (rd_addr)
      `SCSS_ADDR_CH1_LINE: rd_mux = {10'h000, ch1_line_status_r};
      `SCSS_ADDR_CH2_LINE: rd_mux = {10'h000, ch2_line_status_r};
      `SCSS_ADDR_CH1_CFG: rd_mux = ch1_line_settings_r;
      `SCSS_ADDR_CH1_PROT: rd_mux = {12'h000, ch1_protocol_select_r};
      `SCSS_ADDR_CH2_CFG: rd_mux = ch2_line_settings_r;
      `SCSS_ADDR_CH2_PROT: rd_mux = {12'h000, ch2_protocol_select_r};
      `SCSS_ADDR_STATION: rd_mux = {11'h000, host_station_number_r};
      default: rd_map = 1'b0;
    endcase
  end

  // rd_data keeps the last answer, so a slow reader still finds it after the strobe
  always @* begin
    rd_data_nxt = rd_data;
    rd_valid_nxt = rd_en;
    rd_hit_nxt = rd_en & rd_map;
    if (rd_en) begin
      rd_data_nxt = rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer memory read port: answer registers

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
    end else if (ce) begin
      rd_data <= rd_data_nxt;
      rd_valid <= rd_valid_nxt;
      rd_hit <= rd_hit_nxt;
    end
  end
endmodule // scss_status_bank
`default_nettype wire

/* sim/scss_status_bank_assertions.sv */
// checker for the status bank read port, output lines and settings refusal
`timescale 1ns/1ps
`default_nettype none
module scss_status_bank_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic set_load,
  input wire logic [15:0] ch2_cfg_in,
  input wire logic [3:0] ch1_prot_in,
  input wire logic ch1_rts_req,
  input wire logic ch2_dtr_req,
  input wire logic rd_en,
  input wire logic [11:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_hit,
  input wire logic ch1_request_to_send_out,
  input wire logic ch2_dte_ready_out,
  input wire logic set_reject
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_valid; ce && rd_en |=> rd_valid; endproperty
  a_valid: assert property (p_valid) else $error("read not answered");
  property p_quiet; ce && !rd_en |=> !rd_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without read");
  property p_line1; ce && rd_en && rd_addr == 12'h254 |=> rd_hit && rd_data[15:6] == 10'h000; endproperty
  a_line1: assert property (p_line1) else $error("line status word wrong");
  property p_top; rd_hit |-> rd_valid && rd_data[15:12] == 4'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits not zero");
  property p_miss; ce && rd_en && rd_addr == 12'h255 |=> !rd_hit && rd_data == 16'h0000; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read hit");
  property p_rts; ce |=> ch1_request_to_send_out == $past(ch1_rts_req); endproperty
  a_rts: assert property (p_rts) else $error("rts not from firmware");
  property p_dtr; ce |=> ch2_dte_ready_out == $past(ch2_dtr_req); endproperty
  a_dtr: assert property (p_dtr) else $error("dtr not from firmware");
  property p_baud; ce && set_load && ch2_cfg_in[11:8] == 4'hc |=> set_reject; endproperty
  a_baud: assert property (p_baud) else $error("fast rate on ch2 taken");
  property p_prot; ce && set_load && ch1_prot_in > 4'h9 && ch1_prot_in < 4'he |=> set_reject; endproperty
  a_prot: assert property (p_prot) else $error("bad protocol taken");
  property p_stn; ce && rd_en && rd_addr == 12'h2a4 |=> rd_data[15:5] == 11'h000; endproperty
  a_stn: assert property (p_stn) else $error("station out of range");
endmodule // scss_status_bank_chk
bind scss_status_bank scss_status_bank_chk u_scss_status_bank_chk (.*);
`default_nettype wire

/* sim/scss_rs232_peer.sv */
// rs-232 peer: drives one channel's input control lines
`timescale 1ns/1ps
`default_nettype none
module scss_rs232_peer (
  input wire logic [3:0] lvl,
  output logic dsr,
  output logic dcd,
  output logic cts,
  output logic ri
);
  assign {ri, cts, dcd, dsr} = lvl;
endmodule // scss_rs232_peer
`default_nettype wire

/* sim/scss_status_bank_tb.sv */
// testbench for the serial channel status bank
`timescale 1ns/1ps
`default_nettype none
module scss_status_bank_tb;
  logic clk = 1'b0, rstn = 1'b0, set_load = 1'b0, rd_en = 1'b0, ce = 1'b1;
  logic [15:0] c1 = 16'h0000, c2 = 16'h0000;
  logic [3:0] p1 = 4'h0, p2 = 4'h0, l1 = 4'h0, l2 = 4'h0, f = 4'h0;
  logic [4:0] stn = 5'h00;
  logic [11:0] rd_addr = 12'h000;
  wire logic [15:0] rd_data;
  wire logic s1, d1, c1p, r1, s2, d2, c2p, r2, rd_valid, rd_hit, o1, o2, o3, o4, rej;
  int n_errors = 0, compares = 0;
  always #2.5 clk = ~clk;
  scss_rs232_peer u_scss_rs232_peer_ch1 (.lvl(l1), .dsr(s1), .dcd(d1), .cts(c1p), .ri(r1));
  scss_rs232_peer u_scss_rs232_peer_ch2 (.lvl(l2), .dsr(s2), .dcd(d2), .cts(c2p), .ri(r2));
  scss_status_bank #(.REFRESH_CYC(16)) u_scss_status_bank (.clk(clk), .rstn(rstn), .ce(ce),
    .set_load(set_load), .ch1_cfg_in(c1), .ch2_cfg_in(c2), .ch1_prot_in(p1), .ch2_prot_in(p2),
    .station_in(stn), .ch1_rts_req(f[3]), .ch1_dtr_req(f[2]), .ch2_rts_req(f[1]), .ch2_dtr_req(f[0]),
    .ch1_dsr_pin(s1), .ch1_dcd_pin(d1), .ch1_cts_pin(c1p), .ch1_ri_pin(r1), .ch2_dsr_pin(s2),
    .ch2_dcd_pin(d2), .ch2_cts_pin(c2p), .ch2_ri_pin(r2), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit), .ch1_request_to_send_out(o1),
    .ch1_dte_ready_out(o2), .ch2_request_to_send_out(o3), .ch2_dte_ready_out(o4), .set_reject(rej));
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic hit);
    int i;
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    for (i = 0; i < 3 && rd_valid !== 1'b1; i++) @(negedge clk);
    if (rd_valid !== 1'b1) begin
      n_errors++;
      results();
    end
    cmp("hit", {15'h0000, hit}, {15'h0000, rd_hit});
    cmp("data", exp, rd_data);
  endtask
  task automatic load(input logic [15:0] a, b, input logic [3:0] pa, pb, input logic [4:0] s, input logic rj);
    @(negedge clk);
    {c1, c2, p1, p2, stn, set_load} = {a, b, pa, pb, s, 1'b1};
    @(negedge clk);
    set_load = 1'b0;
    cmp("reject", {15'h0000, rj}, {15'h0000, rej});
  endtask
  task automatic t_settings();
    load(16'hfcff, 16'h0b5a, 4'hf, 4'he, 5'h1f, 1'b0);
    rd(12'h2a0, 16'h0cff, 1'b1);
    rd(12'h2a2, 16'h0b5a, 1'b1);
    rd(12'h2a1, 16'h000f, 1'b1);
    rd(12'h2a3, 16'h000e, 1'b1);
    rd(12'h2a4, 16'h001f, 1'b1);
  endtask
  task automatic t_reject();
    load(16'h0000, 16'h0c00, 4'h0, 4'h0, 5'h00, 1'b1);
    load(16'h0d00, 16'h0000, 4'h0, 4'h0, 5'h00, 1'b1);
    rd(12'h2a0, 16'h0cff, 1'b1);
    rd(12'h2a2, 16'h0b5a, 1'b1);
  endtask
  task automatic t_prot();
    int k;
    for (k = 0; k < 16; k++) begin
      load(16'h0000, 16'h0000, 4'(k), 4'h0, 5'h00, k > 9 && k < 14);
      rd(12'h2a1, (k > 9 && k < 14) ? 16'h0009 : 16'(k), 1'b1);
    end
  endtask
  task automatic t_lines(input logic [3:0] a, b, fw, input logic [15:0] e1, e2);
    @(negedge clk);
    {l1, l2, f} = {a, b, fw};
    repeat (40) @(negedge clk);
    cmp("outs", {12'h000, fw}, {12'h000, o1, o2, o3, o4});
    rd(12'h254, e1, 1'b1);
    rd(12'h264, e2, 1'b1);
    rd(12'h255, 16'h0000, 1'b0);
  endtask
  task automatic t_reset();
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    cmp("reset outs", 16'h0000, {11'h000, o1, o2, o3, o4, rej});
    rstn = 1'b1;
    rd(12'h2a0, 16'h0000, 1'b1);
    rd(12'h2a4, 16'h0000, 1'b1);
    rd(12'h264, 16'h0000, 1'b1);
  endtask
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    load(16'h0fff, 16'h0fff, 4'h1, 4'h1, 5'h01, 1'b0);
    ce = 1'b1;
    rd(12'h2a0, 16'h0000, 1'b1);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_settings();
    t_reject();
    t_prot();
    t_lines(4'h1, 4'he, 4'hd, 16'h0007, 16'h003c);
    t_lines(4'h0, 4'h0, 4'h2, 16'h0000, 16'h0001);
    t_reset();
    t_freeze();
    results();
  end
endmodule // scss_status_bank_tb
`default_nettype wire
